// ===== rtl/sfc_pkg.sv
// package for the sensor front end control block
package sfc_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_REG_MODE = 8'h00;  // regulator_mode_ctrl
  localparam logic [7:0] OFF_AMP1_GO = 8'h04;  // amp1_gain_offset
  localparam logic [7:0] OFF_AMP1_CS = 8'h08;  // amp1_chop_second_gain
  localparam logic [7:0] OFF_AMP2_OFS = 8'h0c;  // amp2_offset_level
  localparam logic [7:0] OFF_AMP_EN = 8'h10;  // amp_enable_filter_offset
  localparam logic [7:0] OFF_FLT_CG = 8'h14;  // filter_cutoff_gain
  localparam logic [7:0] OFF_FLT_CS = 8'h18;  // filter_clock_status_ctrl
  localparam logic [7:0] OFF_FLT_DIV = 8'h1c;  // filter_clock_divider
  localparam logic [7:0] OFF_ADC_CTL = 8'h20;  // conversion start and channel
  // ------------------------------------------------------------
  // field positions and masks
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_REG_MODE = 8'h03;  // implemented mode bits
  localparam logic [7:0] MASK_AMP_EN = 8'hdf;  // bit 5 unused
  localparam logic [7:0] MASK_FLT_CS = 8'h3c;  // writable prescaler/auto bits
  localparam logic [7:0] MASK_AMP1_CS = 8'h9f;  // reserved bits 6..5 kept zero
  localparam int POS_AMP_EN = 7;  // amp_enable bit
  localparam int POS_AMP2_GAIN = 6;  // second_amp_gain_sel bit
  localparam int POS_CHOP = 7;  // chopper_enable bit
  localparam int POS_AUTO = 5;  // auto_conversion_enable bit
  localparam int POS_READY = 6;  // filter_ready_flag bit
  localparam int POS_START = 0;  // start bit in adc control
  localparam int POS_IRQF = 1;  // filter_interrupt_flag in adc control
  localparam logic [7:0] RESET_VAL = 8'h00;  // all fields clear
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;  // system clock rate
  localparam int CHOP_HZ = 12_000;  // chopper clock rate
  localparam int CHOP_HALF = CLK_HZ / (2 * CHOP_HZ);  // cycles per half period
  localparam int PRE_MIN_LOG2 = 3;  // code 000 divides by 8
  localparam int ADC_CONV_CYC = 16;  // modelled conversion length
  localparam logic [3:0] CH_FILTER = 4'h5;  // channel code of filter output
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;  // regulator mode field
    logic pin_oe;  // output pin driven
    logic bypass;  // supply passed straight through
    logic reg_on;  // regulator running
  } sfc_reg_t;
  typedef struct packed {
    logic start;  // conversion start pulse
    logic [3:0] channel;  // selected channel
  } sfc_adc_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,  // converter idle
    ST_CONV = 2'b10  // converting
  } sfc_state_t;
endpackage : sfc_pkg

// ===== rtl/sfc_top.sv
// sensor front end control: registers, clocks and conversion steering
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// - mode 00 float, 01 bypass, 1x on
// - unimplemented mode and enable bits read zero
// - enable zero powers down all three amplifiers
// - first gain 8,16,32,64, else 128
// - first offset code over 32 times supply
// - chopper enable gives 12kHz chopping clock
// - second gain one plus three code/32
// - second amp offset code over 256
// - second gain bit 0 x2, 1 x1
// - filter offset code over 32 times supply
// - cutoff code selects 9 to 12 Hz
// - filter gain 56 plus four times code
// - filter clock is prescaled over divider+1
// - prescaler divides system clock by 8..1024
// - auto mode forces channel to filter output
// - software start accepted in auto mode
// - newest start request wins when busy
// - automatic conversion raises filter interrupt request
// - ready rise sets flag, triggers auto conversion
// - prescaler code 000 eight, doubling each step
// - divider zero means divide by one
module sfc_top
  import sfc_pkg::*;
#(
  parameter int CHOP_CYC = CHOP_HALF  // half period of chopper clock
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic FILTER_READY_PIN,
  input wire logic ADC_DONE,
  output sfc_reg_t REG_CTRL,
  output logic AMP1_PD,
  output logic AMP2_PD,
  output logic FILT_PD,
  output logic [2:0] FIRST_STAGE_GAIN_CODE,
  output logic [7:0] FIRST_STAGE_GAIN,
  output logic [4:0] FIRST_AMP_OFFSET_CODE,
  output logic [4:0] SECOND_STAGE_GAIN_CODE,
  output logic [7:0] SECOND_AMP_OFFSET_CODE,
  output logic [1:0] SECOND_AMP_GAIN,
  output logic [4:0] FILTER_AMP_OFFSET_CODE,
  output logic [1:0] LOWPASS_CUTOFF_CODE,
  output logic [5:0] FILTER_GAIN_CODE,
  output logic [8:0] FILTER_GAIN,
  output logic CHOP_CLK,
  output logic FILTER_CLK_EN,
  output sfc_adc_t ADC_REQ,
  output logic ADC_BUSY,
  output logic FILTER_IRQ
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [7:0] r_mode;  // regulator mode
  logic [7:0] r_a1go;  // first amp gain/offset
  logic [7:0] r_a1cs;  // chop and second gain
  logic [7:0] r_a2o;  // second amp offset
  logic [7:0] r_en;  // enable and filter offset
  logic [7:0] r_fcg;  // cutoff and gain
  logic [7:0] r_fcs;  // prescaler and auto bit
  logic [7:0] r_div;  // divider value
  logic [3:0] r_chan;  // software channel
  logic irq_flag;  // filter interrupt flag
  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic ap_wr;  // pending write
  logic [7:0] ap_addr;  // latched address
  logic sw_start;  // software start pulse
  logic sw_irq_clr;  // software clear pulse
  logic ready_rise;  // ready edge event
  logic [7:0] rd_mux;  // read value
  logic sync1, sync2, sync3;  // ready synchroniser
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  // latch address phase of a write
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
    end else if (HREADY) begin
      ap_wr <= HSEL && HTRANS[1] && HWRITE;
      ap_addr <= HADDR[7:0];
    end
  end
  // register writes, reset to zero
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      r_mode <= RESET_VAL;
      r_a1go <= RESET_VAL;
      r_a1cs <= RESET_VAL;
      r_a2o <= RESET_VAL;
      r_en <= RESET_VAL;
      r_fcg <= RESET_VAL;
      r_fcs <= RESET_VAL;
      r_div <= RESET_VAL;
      r_chan <= 4'h0;
    end else if (ap_wr) begin
      case (ap_addr)
        OFF_REG_MODE: r_mode <= HWDATA[7:0] & MASK_REG_MODE;
        OFF_AMP1_GO: r_a1go <= HWDATA[7:0];
        OFF_AMP1_CS: r_a1cs <= HWDATA[7:0] & MASK_AMP1_CS;
        OFF_AMP2_OFS: r_a2o <= HWDATA[7:0];
        OFF_AMP_EN: r_en <= HWDATA[7:0] & MASK_AMP_EN;
        OFF_FLT_CG: r_fcg <= HWDATA[7:0];
        OFF_FLT_CS: r_fcs <= HWDATA[7:0] & MASK_FLT_CS;
        OFF_FLT_DIV: r_div <= HWDATA[7:0];
        OFF_ADC_CTL: r_chan <= HWDATA[7:4];
        default: ;  // unmapped writes ignored
      endcase
    end
  end
  assign sw_start = ap_wr && (ap_addr == OFF_ADC_CTL) && HWDATA[POS_START];
  assign sw_irq_clr = ap_wr && (ap_addr == OFF_ADC_CTL) && HWDATA[POS_IRQF];
  // read mux, unmapped reads zero
  always_comb begin
    case (HADDR[7:0])
      OFF_REG_MODE: rd_mux = r_mode;
      OFF_AMP1_GO: rd_mux = r_a1go;
      OFF_AMP1_CS: rd_mux = r_a1cs;
      OFF_AMP2_OFS: rd_mux = r_a2o;
      OFF_AMP_EN: rd_mux = r_en;
      OFF_FLT_CG: rd_mux = r_fcg;
      OFF_FLT_CS: rd_mux = r_fcs | {1'b0, sync3, 6'h00};
      OFF_FLT_DIV: rd_mux = r_div;
      OFF_ADC_CTL: rd_mux = {r_chan, 1'b0, ADC_BUSY, irq_flag, 1'b0};
      default: rd_mux = 8'h00;
    endcase
  end
  // read data registered at end of address phase
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      HRDATA <= 32'h0;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HRDATA <= {24'h0, rd_mux};
    end
  end
  // ------------------------------------------------------------
  // regulator and amplifier controls
  // ------------------------------------------------------------
  // gain of first stage from code
  function automatic logic [7:0] first_gain(input logic [2:0] c);
    case (c)
      3'h0: first_gain = 8'h08;
      3'h1: first_gain = 8'h10;
      3'h2: first_gain = 8'h20;
      3'h3: first_gain = 8'h40;
      default: first_gain = 8'h80;
    endcase
  endfunction : first_gain
  // regulator decode
  always_comb begin
    REG_CTRL.mode = r_mode[1:0];
    REG_CTRL.pin_oe = (r_mode[1:0] != 2'b00);
    REG_CTRL.bypass = (r_mode[1:0] == 2'b01);
    REG_CTRL.reg_on = r_mode[1];
  end
  assign AMP1_PD = !r_en[POS_AMP_EN];
  assign AMP2_PD = !r_en[POS_AMP_EN];
  assign FILT_PD = !r_en[POS_AMP_EN];
  assign FIRST_STAGE_GAIN_CODE = r_a1go[7:5];
  assign FIRST_STAGE_GAIN = first_gain(r_a1go[7:5]);
  assign FIRST_AMP_OFFSET_CODE = r_a1go[4:0];
  assign SECOND_STAGE_GAIN_CODE = r_a1cs[4:0];
  assign SECOND_AMP_OFFSET_CODE = r_a2o;
  assign SECOND_AMP_GAIN = r_en[POS_AMP2_GAIN] ? 2'd1 : 2'd2;
  assign FILTER_AMP_OFFSET_CODE = r_en[4:0];
  assign LOWPASS_CUTOFF_CODE = r_fcg[7:6];
  assign FILTER_GAIN_CODE = r_fcg[5:0];
  assign FILTER_GAIN = 9'd56 + {1'b0, r_fcg[5:0], 2'b00};
  // ------------------------------------------------------------
  // chopper clock
  // ------------------------------------------------------------
  logic [15:0] chop_cnt;  // half period counter
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      chop_cnt <= 16'h0;
      CHOP_CLK <= 1'b0;
    end else if (!r_a1cs[POS_CHOP]) begin
      chop_cnt <= 16'h0;
      CHOP_CLK <= 1'b0;
    end else if (chop_cnt == 16'(CHOP_CYC - 1)) begin
      chop_cnt <= 16'h0;
      CHOP_CLK <= !CHOP_CLK;
    end else begin
      chop_cnt <= chop_cnt + 16'h1;
    end
  end
  // ------------------------------------------------------------
  // filter clock: prescaler then divider
  // ------------------------------------------------------------
  logic [9:0] pre_cnt;  // free prescaler count
  logic [9:0] pre_lim;  // prescale limit
  logic pre_tick;  // prescaled enable
  logic [7:0] div_cnt;  // divider counter
  // shift amount widened to four bits so codes above 4 do not wrap
  assign pre_lim = 10'((11'h1 << (4'(r_fcs[4:2]) + 4'(PRE_MIN_LOG2)))
                       - 11'h1);
  assign pre_tick = (pre_cnt >= pre_lim);
  // prescaler counter
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pre_cnt <= 10'h0;
    end else if (!r_en[POS_AMP_EN] || pre_tick) begin
      pre_cnt <= 10'h0;
    end else begin
      pre_cnt <= pre_cnt + 10'h1;
    end
  end
  // divider counter
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_cnt <= 8'h0;
      FILTER_CLK_EN <= 1'b0;
    end else if (!r_en[POS_AMP_EN]) begin
      div_cnt <= 8'h0;
      FILTER_CLK_EN <= 1'b0;
    end else if (pre_tick && div_cnt >= r_div) begin
      div_cnt <= 8'h0;
      FILTER_CLK_EN <= 1'b1;
    end else begin
      div_cnt <= pre_tick ? div_cnt + 8'h1 : div_cnt;
      FILTER_CLK_EN <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // ready flag, interrupt and conversion control
  // ------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= FILTER_READY_PIN;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic ready_q;  // accepted ready level
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ready_q <= 1'b0;
    end else if (sync2 == sync3) begin
      ready_q <= sync3;
    end
  end
  assign ready_rise = (sync2 == sync3) && sync3 && !ready_q;
  // sticky flag, set beats clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_flag <= 1'b0;
    end else if (ready_rise) begin
      irq_flag <= 1'b1;
    end else if (sw_irq_clr) begin
      irq_flag <= 1'b0;
    end
  end
  assign FILTER_IRQ = irq_flag;
  logic auto_start;  // filter triggered start
  logic any_start;  // either start
  sfc_state_t state;  // converter state
  logic [4:0] conv_cnt;  // conversion timer
  assign auto_start = ready_rise && r_fcs[POS_AUTO];
  assign any_start = auto_start || sw_start;
  // newest request restarts the conversion
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_IDLE;
      conv_cnt <= 5'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (any_start) begin
            state <= ST_CONV;
            conv_cnt <= 5'h0;
          end
        end
        ST_CONV: begin
          if (any_start) begin
            conv_cnt <= 5'h0;
          end else if (ADC_DONE || conv_cnt == 5'(ADC_CONV_CYC - 1)) begin
            state <= ST_IDLE;
          end else begin
            conv_cnt <= conv_cnt + 5'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign ADC_BUSY = (state == ST_CONV);
  // start pulse and channel to converter
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ADC_REQ <= '0;
    end else begin
      ADC_REQ.start <= any_start;
      ADC_REQ.channel <= r_fcs[POS_AUTO] ? CH_FILTER : r_chan;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_rise_seen;
    ready_rise && r_fcs[POS_AUTO];
  endsequence
  property p_auto_start;
    @(posedge CLK) disable iff (RESET) s_rise_seen |=> ADC_REQ.start && irq_flag;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto start missing");
  property p_chan;
    @(posedge CLK) disable iff (RESET) r_fcs[POS_AUTO] |=> ADC_REQ.channel == CH_FILTER;
  endproperty
  a_chan: assert property (p_chan) else $error("channel not forced");
  property p_pd;
    @(posedge CLK) disable iff (RESET) (AMP1_PD == AMP2_PD) && (AMP2_PD == FILT_PD);
  endproperty
  a_pd: assert property (p_pd) else $error("power downs differ");
  property p_mode;
    @(posedge CLK) disable iff (RESET) REG_CTRL.pin_oe == (REG_CTRL.bypass || REG_CTRL.reg_on);
  endproperty
  a_mode: assert property (p_mode) else $error("regulator decode wrong");
  property p_chop_off;
    @(posedge CLK) disable iff (RESET) !r_a1cs[POS_CHOP] |=> !CHOP_CLK;
  endproperty
  a_chop_off: assert property (p_chop_off) else $error("chop clock while off");
  property p_div_hold;
    @(posedge CLK) disable iff (RESET) !r_en[POS_AMP_EN] |=> div_cnt == 8'h0 && !FILTER_CLK_EN;
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider not held");
  property p_sw_start;
    @(posedge CLK) disable iff (RESET) sw_start |=> ADC_REQ.start ##0 ADC_BUSY;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start lost");
  property p_gain;
    @(posedge CLK) disable iff (RESET) r_a1go[7] |-> FIRST_STAGE_GAIN == 8'h80;
  endproperty
  a_gain: assert property (p_gain) else $error("first gain wrong");
  property p_restart;
    @(posedge CLK) disable iff (RESET) (ADC_BUSY && any_start) |=> conv_cnt == 5'h0 && ADC_BUSY;
  endproperty
  a_restart: assert property (p_restart) else $error("newest start not served");
  property p_rd2;
    @(posedge CLK) disable iff (RESET) r_mode[7:2] == 6'h0 && r_en[5] == 1'b0;
  endproperty
  a_rd2: assert property (p_rd2) else $error("unused bits set");
  // filter pulse lasts one cycle, prescaler never ticks twice in a row
  property p_fclk_pulse;
    @(posedge CLK) disable iff (RESET) FILTER_CLK_EN |=> !FILTER_CLK_EN;
  endproperty
  a_fclk_pulse: assert property (p_fclk_pulse) else $error("filter pulse too long");
  // conversion timer ends the conversion when no answer comes
  property p_conv_limit;
    @(posedge CLK) disable iff (RESET)
      (ADC_BUSY && !any_start && conv_cnt == 5'(ADC_CONV_CYC - 1)) |=> !ADC_BUSY;
  endproperty
  a_conv_limit: assert property (p_conv_limit) else $error("conversion overran");
  // clear without a ready edge empties the flag
  property p_irq_clr;
    @(posedge CLK) disable iff (RESET) (sw_irq_clr && !ready_rise) |=> !irq_flag;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("flag not cleared");
endmodule : sfc_top

// ===== verification/sfc_adc_model.sv
// behavioural converter model that answers conversion starts from the block
`timescale 1ns/10ps
module sfc_adc_model
  import sfc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire sfc_adc_t req,
  input wire logic slow,
  output logic done,
  output int n_starts
);
  // ------------------------------------------------------------
  // conversion timer
  // ------------------------------------------------------------
  int cnt;  // cycles left in the running conversion
  // each start restarts the timer, so the newest request is served
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      done <= 1'b0;
      n_starts <= 0;
    end else begin
      done <= 1'b0;
      if (req.start === 1'b1) begin
        // count the start and restart the timer
        n_starts <= n_starts + 1;
        cnt <= 6;
      end else if (cnt > 0) begin
        // slow mode never answers, so the block's own limit must end it
        cnt <= cnt - 1;
        done <= (cnt == 1) && !slow;
      end
    end
  end
endmodule : sfc_adc_model

// ===== verification/sfc_top_tb.sv
// self-checking bench for the sensor front end control block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sfc_top_tb
  import sfc_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int CHOP_T = 4;  // short chopper half period
  localparam int LIM = 5000;  // bound of every wait
  logic CLK, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;  // whole words only
  wire logic HREADY;
  logic HREADYOUT, HRESP, FILTER_READY_PIN = 1'b0, ADC_DONE, slow = 1'b0;
  sfc_reg_t REG_CTRL;
  logic AMP1_PD, AMP2_PD, FILT_PD, CHOP_CLK, FILTER_CLK_EN, ADC_BUSY, FILTER_IRQ;
  logic [2:0] FIRST_STAGE_GAIN_CODE;
  logic [7:0] FIRST_STAGE_GAIN, SECOND_AMP_OFFSET_CODE;
  logic [4:0] FIRST_AMP_OFFSET_CODE, SECOND_STAGE_GAIN_CODE, FILTER_AMP_OFFSET_CODE;
  logic [1:0] SECOND_AMP_GAIN, LOWPASS_CUTOFF_CODE;
  logic [5:0] FILTER_GAIN_CODE;
  logic [8:0] FILTER_GAIN;
  sfc_adc_t ADC_REQ;
  int n_mismatch = 0, samples_checked = 0, n_starts;
  logic [31:0] rdat;  // last read data
  logic [2:0] pre [5] = '{3'h0, 3'h0, 3'h2, 3'h6, 3'h7};  // prescaler codes
  logic [7:0] dv [5] = '{8'h00, 8'h03, 8'h01, 8'h00, 8'h02};  // divider values
  assign HREADY = HREADYOUT;  // single slave drives the bus ready
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  sfc_top #(.CHOP_CYC(CHOP_T)) sfc_top_inst (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .FILTER_READY_PIN(FILTER_READY_PIN), .ADC_DONE(ADC_DONE), .REG_CTRL(REG_CTRL),
    .AMP1_PD(AMP1_PD), .AMP2_PD(AMP2_PD), .FILT_PD(FILT_PD),
    .FIRST_STAGE_GAIN_CODE(FIRST_STAGE_GAIN_CODE), .FIRST_STAGE_GAIN(FIRST_STAGE_GAIN),
    .FIRST_AMP_OFFSET_CODE(FIRST_AMP_OFFSET_CODE),
    .SECOND_STAGE_GAIN_CODE(SECOND_STAGE_GAIN_CODE),
    .SECOND_AMP_OFFSET_CODE(SECOND_AMP_OFFSET_CODE), .SECOND_AMP_GAIN(SECOND_AMP_GAIN),
    .FILTER_AMP_OFFSET_CODE(FILTER_AMP_OFFSET_CODE),
    .LOWPASS_CUTOFF_CODE(LOWPASS_CUTOFF_CODE), .FILTER_GAIN_CODE(FILTER_GAIN_CODE),
    .FILTER_GAIN(FILTER_GAIN), .CHOP_CLK(CHOP_CLK), .FILTER_CLK_EN(FILTER_CLK_EN),
    .ADC_REQ(ADC_REQ), .ADC_BUSY(ADC_BUSY), .FILTER_IRQ(FILTER_IRQ));
  sfc_adc_model sfc_adc_model_inst (.clk(CLK), .reset(RESET), .req(ADC_REQ),
    .slow(slow), .done(ADC_DONE), .n_starts(n_starts));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // picks a watched signal: 0 filter pulse, 1 chopper, 2 bus ready
  function automatic logic sig(input int s);
    return (s == 0) ? FILTER_CLK_EN : (s == 1) ? CHOP_CLK : HREADYOUT;
  endfunction : sig
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // bounded wait for a level at a rising edge
  task automatic wait_lvl(input int s, input logic v, output int k);
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (sig(s) !== v && k < LIM);
    if (sig(s) !== v) begin
      n_mismatch++;
      test_done();
    end
  endtask : wait_lvl
  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    wait_lvl(2, 1'b1, k);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_lvl(2, 1'b1, k);
    rdat = HRDATA;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask : rd
  // cycles between two rises, taken after two discarded periods
  task automatic period(input int s, output int n);
    int k;
    repeat (2) begin
      wait_lvl(s, 1'b0, k);
      wait_lvl(s, 1'b1, k);
      wait_lvl(s, 1'b0, n);
      wait_lvl(s, 1'b1, k);
      n += k;
    end
  endtask : period
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    int b;
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
    @(negedge CLK);
    `CHK({AMP1_PD, AMP2_PD, FILT_PD, REG_CTRL}, 8'he0)
    `CHK({FIRST_STAGE_GAIN, SECOND_AMP_GAIN, FILTER_GAIN}, 19'h04438)
    for (int m = 0; m < 4; m++) begin
      wr(OFF_REG_MODE, 32'hfc | m);
      rd(OFF_REG_MODE, m);
      `CHK(REG_CTRL, {2'(m), m != 0, m == 1, m > 1})
    end
    repeat (20) @(posedge CLK);  // regulator settles before amp setup
    for (int c = 0; c < 8; c++) begin
      wr(OFF_AMP1_GO, {c[2:0], 5'(31 - c)});
      @(negedge CLK);
      `CHK(FIRST_STAGE_GAIN, (c > 3) ? 8'h80 : 8'(8 << c))
      `CHK(FIRST_AMP_OFFSET_CODE, 5'(31 - c))
      `CHK(FIRST_STAGE_GAIN_CODE, c[2:0])
    end
    wr(OFF_AMP1_CS, 32'h9a);  // reserved bits 6..5 written as zero
    rd(OFF_AMP1_CS, 32'h9a);
    `CHK(SECOND_STAGE_GAIN_CODE, 5'h1a)
    period(1, n);
    `CHK(n, 2 * CHOP_T)
    wr(OFF_AMP1_CS, 32'h1a);
    @(posedge CLK);
    b = 0;
    repeat (20) begin
      @(posedge CLK);
      b += (CHOP_CLK !== 1'b0);
    end
    `CHK(b, 0)
    wr(OFF_AMP2_OFS, 32'ha5);
    rd(OFF_AMP2_OFS, 32'ha5);
    `CHK(SECOND_AMP_OFFSET_CODE, 8'ha5)
    wr(OFF_AMP_EN, 32'hff);
    rd(OFF_AMP_EN, 32'hdf);
    `CHK({AMP1_PD, AMP2_PD, FILT_PD, SECOND_AMP_GAIN}, 5'h01)
    `CHK(FILTER_AMP_OFFSET_CODE, 5'h1f)
    wr(OFF_FLT_CG, 32'hbf);
    @(negedge CLK);
    `CHK({LOWPASS_CUTOFF_CODE, FILTER_GAIN}, {2'h2, 9'h134})
    `CHK(FILTER_GAIN_CODE, 6'h3f)
    for (int i = 0; i < 5; i++) begin
      wr(OFF_FLT_CS, {27'h0, pre[i], 2'h0});
      wr(OFF_FLT_DIV, {24'h0, dv[i]});
      period(0, n);
      `CHK(n, (8 << pre[i]) * (dv[i] + 1))
    end
    wr(OFF_FLT_CS, 32'h0);
    wr(OFF_FLT_DIV, 32'h0);
    wr(OFF_AMP_EN, 32'h1f);
    b = 0;
    repeat (100) begin
      @(posedge CLK);
      b += (FILTER_CLK_EN !== 1'b0);
    end
    `CHK({b[3:0], AMP1_PD, AMP2_PD, FILT_PD}, 7'h07)
    wr(OFF_AMP_EN, 32'h80);
    wr(OFF_ADC_CTL, 32'h30);
    repeat (2) @(negedge CLK);
    `CHK(ADC_REQ.channel, 4'h3)
    wr(OFF_FLT_CS, 32'h20);
    repeat (2) @(negedge CLK);
    `CHK(ADC_REQ.channel, CH_FILTER)
    b = n_starts;
    @(posedge CLK);
    FILTER_READY_PIN <= 1'b1;
    repeat (12) @(posedge CLK);
    `CHK(n_starts, b + 1)
    `CHK(FILTER_IRQ, 1'b1)
    rd(OFF_FLT_CS, 32'h60);
    `CHK(ADC_BUSY, 1'b0)
    wr(OFF_ADC_CTL, 32'h03);  // start and clear the interrupt flag
    repeat (3) @(posedge CLK);
    `CHK({n_starts == b + 2, FILTER_IRQ}, 2'h2)
    slow <= 1'b1;
    repeat (20) @(posedge CLK);
    wr(OFF_ADC_CTL, 32'h01);
    wr(OFF_ADC_CTL, 32'h01);
    repeat (16) @(posedge CLK);
    `CHK({n_starts == b + 4, ADC_BUSY}, 2'h3)
    repeat (4) @(posedge CLK);
    `CHK({ADC_BUSY, HRESP}, 2'h0)
    wr(8'h40, 32'hff);
    rd(8'h40, 32'h0);
    test_done();
  end
endmodule : sfc_top_tb
